// ===== include/iha_regs.svh
`ifndef IHA_REGS_SVH
`define IHA_REGS_SVH
// register indices
`define IHA_R_SAC 8'h00
`define IHA_R_HTC 8'h01
`define IHA_R_STA 8'h02
`define IHA_R_HDS 8'h03
`define IHA_R_TMP 8'h06
`define IHA_R_CFG 8'h07
`define IHA_R_T12 8'h0d
// field positions (low bit of each field)
`define IHA_B_OVR 22
`define IHA_B_RW1 20
`define IHA_B_HEN 19
`define IHA_B_TRG 18
`define IHA_B_FRM 17
`define IHA_B_WD1 9
`define IHA_B_DONE 8
`define IHA_B_TBS 20
`define IHA_B_SEL 18
`define IHA_B_NB1 16
`define IHA_B_TEN 0
`define IHA_B_AVG 1
`define IHA_B_T12 23
// sizes and bus addresses
`define IHA_NREG 64
`define IHA_EE_DEV 7'h50
`define IHA_EE_LAST 8'hff
`define IHA_EE_WORD 8'h00
// bus timing, quarter of a 400 kHz bit
`define IHA_CLK_NS 10
`define IHA_QTR_NS 625
`define IHA_QTR_CYC ((`IHA_QTR_NS + `IHA_CLK_NS - 1) / `IHA_CLK_NS)
`endif

// ===== include/iha_pkg.sv
`default_nettype none
`include "iha_regs.svh"
package iha_pkg;
    typedef enum logic [1:0] {
        CMD_START = 2'b00,
        CMD_WRITE = 2'b01,
        CMD_READ = 2'b10,
        CMD_STOP = 2'b11
    } iha_cmd_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_START = 4'b0001,
        ST_DEV = 4'b0010,
        ST_WADDR = 4'b0011,
        ST_RSTART = 4'b0100,
        ST_RDEV = 4'b0101,
        ST_WR1 = 4'b0110,
        ST_WR2 = 4'b0111,
        ST_READ = 4'b1000,
        ST_STOP = 4'b1001
    } iha_state_t;
    typedef enum logic [1:0] {
        J_LOAD = 2'b00,
        J_TEMP = 2'b01,
        J_MWR = 2'b10,
        J_MRD = 2'b11
    } iha_job_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [23:0] wdata;
    } iha_req_t;
    typedef struct packed {
        logic busy;
        iha_cmd_t cmd;
        logic [1:0] q;
        logic [15:0] div;
        logic [3:0] bitn;
        logic [8:0] sh;
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_oe;
        logic sda_oe;
        logic done;
        logic nack;
        logic [7:0] rx;
    } iha_eng_t;
    typedef struct packed {
        iha_state_t st;
        iha_job_t job;
        logic waiting;
        logic abort;
        logic cmd_valid;
        iha_cmd_t cmd;
        logic [7:0] cmd_byte;
        logic cmd_nack;
        logic [7:0] cnt;
        logic [7:0] gaddr;
        logic [15:0] gdata;
        logic [31:0] rd32;
        logic loading;
        logic trig_prev;
        logic pend_man;
        logic pend_frm;
        logic [2:0] fsync;
        logic [15:0] acc;
        logic [3:0] avg_n;
        logic [11:0] temp;
        logic temp_valid;
        logic ack;
        logic [23:0] rdata;
        logic [`IHA_NREG-1:0][23:0] regs;
    } iha_ctl_t;
endpackage
`default_nettype wire

// ===== hdl/iha_bit_engine.sv
`timescale 1ns/1ns
`default_nettype none
`include "iha_regs.svh"
module iha_bit_engine
    import iha_pkg::*;
#(
    parameter int QTR = `IHA_QTR_CYC
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic cmd_valid_in,
    input wire iha_cmd_t cmd_in,
    input wire logic [7:0] tx_byte_in,
    input wire logic tx_nack_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out,
    output logic scl_oe_out,
    output logic sda_oe_out,
    output logic done_out,
    output logic nack_out,
    output logic [7:0] rx_byte_out
);
    iha_eng_t s;
    iha_eng_t next_s;

    // four quarters per start, data bit or stop; scl held low by a target stalls quarter two
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.scl_s = {s.scl_s[0], scl_in};
        next_s.sda_s = {s.sda_s[0], sda_in};
        if (!s.busy) begin
            if (cmd_valid_in) begin
                next_s.busy = 1'b1;
                next_s.cmd = cmd_in;
                next_s.q = 2'h0;
                next_s.div = 16'h0000;
                next_s.bitn = 4'h0;
                next_s.sh = (cmd_in == CMD_READ) ? {8'hff, tx_nack_in} : {tx_byte_in, 1'b1};
            end
        end else if (s.div != 16'(QTR - 1)) begin
            next_s.div = s.div + 16'h0001;
        end else if (!(s.q == 2'h2 && !s.scl_s[1])) begin
            next_s.div = 16'h0000;
            next_s.q = s.q + 2'h1;
            case (s.cmd)
                CMD_START: begin
                    case (s.q)
                        2'h0: next_s.sda_oe = 1'b0;
                        2'h1: next_s.scl_oe = 1'b0;
                        2'h2: next_s.sda_oe = 1'b1;
                        default: begin
                            next_s.scl_oe = 1'b1;
                            next_s.busy = 1'b0;
                            next_s.done = 1'b1;
                        end
                    endcase
                end
                CMD_STOP: begin
                    case (s.q)
                        2'h0: next_s.sda_oe = 1'b1;
                        2'h1: next_s.scl_oe = 1'b0;
                        2'h2: next_s.sda_oe = 1'b0;
                        default: begin
                            next_s.busy = 1'b0;
                            next_s.done = 1'b1;
                        end
                    endcase
                end
                default: begin
                    case (s.q)
                        2'h0: next_s.sda_oe = ~s.sh[8];
                        2'h1: next_s.scl_oe = 1'b0;
                        2'h2: next_s.sh = {s.sh[7:0], s.sda_s[1]};
                        default: begin
                            next_s.scl_oe = 1'b1;
                            next_s.bitn = s.bitn + 4'h1;
                            if (s.bitn == 4'h8) begin
                                next_s.busy = 1'b0;
                                next_s.done = 1'b1;
                                next_s.rx = s.sh[8:1];
                                next_s.nack = s.sh[0];
                            end
                        end
                    endcase
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // open-drain pins only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_out = s.scl_oe;
    assign sda_oe_out = s.sda_oe;
    assign done_out = s.done;
    assign nack_out = s.nack;
    assign rx_byte_out = s.rx;

    a_start_ends_low: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (s.done && s.cmd == CMD_START) |-> (s.scl_oe && s.sda_oe)) else $error("start left bus released");
    a_stop_releases: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (s.done && s.cmd == CMD_STOP) |-> (!s.scl_oe && !s.sda_oe)) else $error("stop left bus driven");
endmodule
`default_nettype wire

// ===== hdl/iha_host_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "iha_regs.svh"
// Functional notes
// RL1: every reset starts a full 256-byte EEPROM load
// RL2: EEPROM groups: address, then three data bytes
// RL3: EEPROM answers at bus address 0x50
// RL4: no EEPROM answer abandons the load early
// RL5: slave accesses acknowledged but inert during load; here register zero stays reachable during load
// RL6: autoload never writes register zero
// RL7: override bit hands registers to slave port
// RL8: without pull-ups, set override before other writes
// RL9: image disables power-down before single-shot enable
// RL10: unused image bytes all zero or all one
// RL11: frame start launches one sensor read
// RL12: averaging field picks number of averaged readings
// RL13: byte-count field picks one or two bytes
// RL14: bit-select picks twelve bits of sixteen
// RL15: twelve-bit mode uses sixteen-bit window, else byte
// RL16: EEPROM write is one two-byte write
// RL17: writing one to trigger launches a transaction
// RL18: erase EEPROM before programming it through device
// RL19: selected read byte shown in register three
// RL20: direction bit: zero write, one read
// RL21: load-done flag set at end, held till reset
// RL22: register written only after all three bytes
module iha_host_ctrl
    import iha_pkg::*;
#(
    parameter int QTR = `IHA_QTR_CYC
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire iha_req_t reg_req_in,
    input wire logic frame_start_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic reg_ack_out,
    output logic [23:0] reg_rdata_out,
    output logic scl_out,
    output logic sda_out,
    output logic scl_oe_out,
    output logic sda_oe_out,
    output logic [11:0] temp_value_out,
    output logic temp_valid_out,
    output logic load_done_out
);
    iha_ctl_t s;
    iha_ctl_t next_s;
    logic eng_done;
    logic eng_nack;
    logic [7:0] eng_rx;
    logic ovr;
    logic hen;
    logic ten;
    logic ftrg;
    logic mrw;
    logic nb1;
    logic t12;
    logic blocked;
    logic last;
    logic fedge;
    logic medge;
    logic [1:0] avg;
    logic [3:0] tbs;
    logic [5:0] a6;
    logic [11:0] tv;
    logic [15:0] sum;

    // register index lies inside the implemented file
    function automatic logic mapped(input logic [7:0] a);
        return a < 8'(`IHA_NREG);
    endfunction

    // byte lane of the last read result
    function automatic logic [7:0] pick(input logic [31:0] d, input logic [1:0] sel);
        return d[sel * 8 +: 8];
    endfunction

    // sensor value: twelve bits out of sixteen, or the single byte
    function automatic logic [11:0] tval(input logic [15:0] d, input logic [3:0] sel, input logic w12);
        logic [19:0] w;
        w = {d, 4'h0} >> sel;
        return w12 ? w[11:0] : {4'h0, d[7:0]};
    endfunction

    // control fields decoded from the register file
    assign ovr = s.regs[`IHA_R_SAC][`IHA_B_OVR];
    assign hen = s.regs[`IHA_R_HTC][`IHA_B_HEN];
    assign ftrg = s.regs[`IHA_R_HTC][`IHA_B_FRM];
    assign mrw = s.regs[`IHA_R_HTC][`IHA_B_RW1]; // [RL20]
    assign ten = s.regs[`IHA_R_TMP][`IHA_B_TEN];
    assign avg = s.regs[`IHA_R_TMP][`IHA_B_AVG +: 2];
    assign nb1 = s.regs[`IHA_R_CFG][`IHA_B_NB1];
    assign tbs = s.regs[`IHA_R_CFG][`IHA_B_TBS +: 4];
    assign t12 = s.regs[`IHA_R_T12][`IHA_B_T12];
    assign blocked = s.loading && !ovr; // [RL7]
    assign a6 = reg_req_in.addr[5:0];
    assign fedge = s.fsync[1] && !s.fsync[2];
    assign medge = s.regs[`IHA_R_HTC][`IHA_B_TRG] && !s.trig_prev; // [RL17]
    assign last = s.cnt == ((s.job == J_LOAD) ? `IHA_EE_LAST : {7'h00, nb1}); // [RL1] [RL13]
    assign tv = tval(s.rd32[15:0], tbs, t12); // [RL14] [RL15]
    assign sum = s.acc + {4'h0, tv};

    // transaction sequencer, slave port and trigger capture
    always_comb begin
        next_s = s;
        next_s.cmd_valid = 1'b0;
        next_s.temp_valid = 1'b0;
        next_s.ack = 1'b0;
        next_s.fsync = {s.fsync[1:0], frame_start_in};
        next_s.trig_prev = s.regs[`IHA_R_HTC][`IHA_B_TRG];
        // bus command for the current step
        next_s.cmd = CMD_WRITE;
        next_s.cmd_nack = 1'b1;
        case (s.st)
            ST_START, ST_RSTART: next_s.cmd = CMD_START;
            ST_DEV: begin
                if (s.job == J_LOAD) begin
                    next_s.cmd_byte = {`IHA_EE_DEV, 1'b0}; // [RL3]
                end else begin
                    next_s.cmd_byte = {s.regs[`IHA_R_STA][6:0], s.job != J_MWR}; // [RL11] [RL16]
                end
            end
            ST_WADDR: next_s.cmd_byte = `IHA_EE_WORD;
            ST_RDEV: next_s.cmd_byte = {`IHA_EE_DEV, 1'b1}; // [RL3]
            ST_WR1: next_s.cmd_byte = s.regs[`IHA_R_HDS][`IHA_B_WD1 +: 8]; // [RL16]
            ST_WR2: next_s.cmd_byte = s.regs[`IHA_R_CFG][7:0];
            ST_READ: begin
                next_s.cmd = CMD_READ;
                next_s.cmd_nack = last;
            end
            default: next_s.cmd = CMD_STOP;
        endcase
        // step sequencing: issue once, then wait for the engine
        if (s.st == ST_IDLE) begin
            next_s.cnt = 8'h00;
            next_s.waiting = 1'b0;
            next_s.abort = 1'b0;
            if (s.loading) begin
                next_s.job = J_LOAD; // [RL1]
                next_s.st = ST_START;
            end else if (s.pend_man && hen) begin
                next_s.pend_man = 1'b0;
                next_s.job = mrw ? J_MRD : J_MWR; // [RL17] [RL20]
                next_s.st = ST_START;
            end else if (s.pend_frm) begin
                next_s.pend_frm = 1'b0;
                next_s.job = J_TEMP; // [RL11]
                next_s.st = ST_START;
            end
        end else if (!s.waiting) begin
            next_s.cmd_valid = 1'b1;
            next_s.waiting = 1'b1;
        end else if (eng_done) begin
            next_s.waiting = 1'b0;
            case (s.st)
                ST_START: next_s.st = ST_DEV;
                ST_DEV: begin
                    if (eng_nack) begin
                        next_s.abort = 1'b1; // [RL4]
                        next_s.st = ST_STOP;
                    end else if (s.job == J_LOAD) begin
                        next_s.st = ST_WADDR;
                    end else if (s.job == J_MWR) begin
                        next_s.st = ST_WR1;
                    end else begin
                        next_s.st = ST_READ;
                    end
                end
                ST_WADDR: next_s.st = eng_nack ? ST_STOP : ST_RSTART;
                ST_RSTART: next_s.st = ST_RDEV;
                ST_RDEV: next_s.st = eng_nack ? ST_STOP : ST_READ;
                ST_WR1: next_s.st = nb1 ? ST_WR2 : ST_STOP; // [RL16]
                ST_WR2: next_s.st = ST_STOP;
                ST_READ: begin
                    next_s.rd32 = {s.rd32[23:0], eng_rx};
                    next_s.cnt = s.cnt + 8'h01;
                    if (s.job == J_LOAD) begin
                        // address byte then three data bytes, low byte first
                        case (s.cnt[1:0])
                            2'h0: next_s.gaddr = eng_rx; // [RL2]
                            2'h1: next_s.gdata[7:0] = eng_rx;
                            2'h2: next_s.gdata[15:8] = eng_rx;
                            default: begin
                                if (s.gaddr != `IHA_R_SAC && mapped(s.gaddr) && !ovr) begin // [RL6] [RL7]
                                    next_s.regs[s.gaddr[5:0]] = {eng_rx, s.gdata}; // [RL22]
                                end
                            end
                        endcase
                    end
                    if (last) begin
                        next_s.st = ST_STOP;
                    end
                end
                default: begin
                    next_s.st = ST_IDLE;
                    if (s.job == J_LOAD) begin
                        next_s.loading = 1'b0;
                        next_s.regs[`IHA_R_HDS][`IHA_B_DONE] = 1'b1; // [RL21]
                    end else if (!s.abort && s.job != J_MWR) begin
                        next_s.regs[`IHA_R_HDS][7:0] = pick(s.rd32, s.regs[`IHA_R_CFG][`IHA_B_SEL +: 2]); // [RL19]
                        if (s.job == J_TEMP) begin
                            // average 1, 2, 4 or 8 readings
                            next_s.acc = sum;
                            next_s.avg_n = s.avg_n + 4'h1;
                            if (s.avg_n == (4'h1 << avg) - 4'h1) begin // [RL12]
                                next_s.temp = 12'(sum >> avg);
                                next_s.temp_valid = 1'b1;
                                next_s.acc = 16'h0000;
                                next_s.avg_n = 4'h0;
                            end
                        end
                    end
                end
            endcase
        end
        // trigger edges are captured after any clear so a new one is kept
        if (medge) begin
            next_s.pend_man = 1'b1;
        end
        if (fedge && hen && ten && ftrg) begin
            next_s.pend_frm = 1'b1; // [RL11]
        end
        // slave port: always acknowledged, register zero always reachable
        if (reg_req_in.wr || reg_req_in.rd) begin
            next_s.ack = 1'b1; // [RL5]
        end
        if (reg_req_in.rd) begin
            next_s.rdata = 24'h000000;
            if (mapped(reg_req_in.addr) && (!blocked || reg_req_in.addr == `IHA_R_SAC)) begin // [RL5]
                next_s.rdata = s.regs[a6];
            end
        end
        if (reg_req_in.wr && mapped(reg_req_in.addr) && (!blocked || reg_req_in.addr == `IHA_R_SAC)) begin
            if (reg_req_in.addr == `IHA_R_HDS) begin
                next_s.regs[a6][23:`IHA_B_WD1] = reg_req_in.wdata[23:`IHA_B_WD1];
            end else begin
                next_s.regs[a6] = reg_req_in.wdata;
            end
        end
    end

    // state register; a reset always arms the load
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '0;
            s.loading <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // bus engine for start, byte and stop
    iha_bit_engine #(
        .QTR(QTR)
    ) u_eng (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .cmd_valid_in(s.cmd_valid),
        .cmd_in(s.cmd),
        .tx_byte_in(s.cmd_byte),
        .tx_nack_in(s.cmd_nack),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_out(scl_out),
        .sda_out(sda_out),
        .scl_oe_out(scl_oe_out),
        .sda_oe_out(sda_oe_out),
        .done_out(eng_done),
        .nack_out(eng_nack),
        .rx_byte_out(eng_rx)
    );

    // registered outputs
    assign reg_ack_out = s.ack;
    assign reg_rdata_out = s.rdata;
    assign temp_value_out = s.temp;
    assign temp_valid_out = s.temp_valid;
    assign load_done_out = s.regs[`IHA_R_HDS][`IHA_B_DONE];

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence seq_load_begin;
        (s.st == ST_START && s.job == J_LOAD) ##1 (s.cmd_valid && s.cmd == CMD_START);
    endsequence

    a_load_kick: assert property ( // [RL1]
        (s.st == ST_IDLE && s.loading) |=> seq_load_begin) else $error("load did not start");
    a_ee_address: assert property ( // [RL3]
        (s.cmd_valid && s.job == J_LOAD && s.st == ST_DEV) |-> s.cmd_byte == 8'ha0) else $error("bad eeprom address");
    a_load_abandon: assert property ( // [RL4]
        (s.st == ST_DEV && s.waiting && eng_done && eng_nack) |=> s.st == ST_STOP) else $error("load not abandoned");
    a_slave_mute: assert property ( // [RL5]
        (reg_req_in.rd && blocked && reg_req_in.addr != 8'h00) |=> (reg_ack_out && reg_rdata_out == 24'h000000))
        else $error("slave read during load");
    a_reg0_guard: assert property ( // [RL6]
        !(reg_req_in.wr && reg_req_in.addr == 8'h00) |=> $stable(s.regs[0])) else $error("register zero changed");
    a_done_sticky: assert property ( // [RL21]
        load_done_out |=> load_done_out) else $error("load done dropped");
    a_write_len: assert property ( // [RL13]
        (s.st == ST_WR1 && s.waiting && eng_done) |=> ((s.st == ST_WR2) == $past(nb1))) else $error("bad write length");
    a_group_whole: assert property ( // [RL22]
        (s.st == ST_READ && s.job == J_LOAD && s.waiting && eng_done && s.cnt[1:0] != 2'h3 && !reg_req_in.wr)
        |=> $stable(s.regs)) else $error("partial register write");
endmodule
`default_nettype wire

// ===== verification/iha_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
// behavioural eeprom and temperature sensor sharing the host bus
module iha_bus_model #(
    parameter logic [6:0] SENS = 7'h48
) (
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic ee_en_in,
    output logic sda_oe_out
);
    logic [7:0] mem [256];
    logic [7:0] sh, ptr, tx, sv;
    int bitc, nb;
    logic act, rd, ee;
    initial begin
        sda_oe_out = 1'b0;
        sv = 8'h40;
        {act, rd, ee} = 3'h0;
        bitc = 0;
        nb = -1;
    end
    // start and stop conditions
    always @(negedge sda_in) if (scl_in) begin
        bitc = 0;
        nb = -1;
        act = 1'b0;
    end
    always @(posedge sda_in) if (scl_in) act = 1'b0;
    // sample on rising clock; a master nack ends a read
    always @(posedge scl_in) begin
        if (bitc < 8) sh = {sh[6:0], sda_in};
        else if (rd && sda_in) act = 1'b0;
        bitc++;
    end
    // drive acks and read bits while the clock is low
    always @(negedge scl_in) begin
        sda_oe_out = 1'b0;
        if (bitc == 8 && nb < 0) begin
            ee = sh[7:1] == 7'h50;
            act = (ee && ee_en_in) || sh[7:1] == SENS;
            rd = sh[0];
            nb = 0;
            sda_oe_out = act;
        end else if (bitc == 8 && !rd) begin
            if (nb == 0) ptr = sh;
            else if (ee && act) mem[ptr] = sh;
            nb++;
            sda_oe_out = act;
        end else if (bitc == 9) begin
            bitc = 0;
            tx = ee ? mem[ptr] : sv;
            if (rd && act) begin
                if (ee) ptr++;
                else sv++;
                sda_oe_out = !tx[7];
            end
        end else if (rd && act && bitc < 8) sda_oe_out = !tx[7 - bitc];
    end
endmodule
`default_nettype wire

// ===== verification/iha_host_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module iha_host_ctrl_tb;
    import iha_pkg::*;
    logic sys_clk_in, rst_in, frame, ee_en, ack, scl_oe, sda_oe, m_oe, tvalid, done;
    logic [23:0] rdata, r;
    logic [11:0] tval;
    iha_req_t req;
    wire logic scl, sda;
    int n_mismatch, cmp_count, cyc, nval;
    // open-drain lines with pull-ups, so override-first ordering is not forced
    assign scl = !scl_oe;
    assign sda = !(sda_oe || m_oe);
    iha_host_ctrl #(.QTR(2)) i_dut (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_req_in(req), .frame_start_in(frame),
        .scl_in(scl), .sda_in(sda), .reg_ack_out(ack), .reg_rdata_out(rdata), .scl_out(), .sda_out(),
        .scl_oe_out(scl_oe), .sda_oe_out(sda_oe), .temp_value_out(tval), .temp_valid_out(tvalid),
        .load_done_out(done)
    );
    iha_bus_model i_model (.scl_in(scl), .sda_in(sda), .ee_en_in(ee_en), .sda_oe_out(m_oe));
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = !sys_clk_in;
    end
    // cycle count, hang guard and result pulses
    always @(posedge sys_clk_in) begin
        cyc++;
        if (tvalid) nval++;
        if (cyc == 40000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one register access; the ack must follow in the next cycle
    task automatic acc(input logic w, input logic [7:0] a, input logic [23:0] d);
        @(posedge sys_clk_in);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge sys_clk_in);
        req <= '0;
        #1;
        chk({23'h0, ack}, 24'h1);
        r = rdata;
    endtask
    task automatic rst(input logic e);
        @(posedge sys_clk_in);
        ee_en <= e;
        rst_in <= 1'b1;
        repeat (8) @(posedge sys_clk_in);
        rst_in <= 1'b0;
    endtask
    task automatic wait_done(input int lim);
        for (int i = 0; i < lim && done !== 1'b1; i++) begin
            @(posedge sys_clk_in);
            #1;
        end
        chk({23'h0, done}, 24'h1);
    endtask
    task automatic frames(input int n);
        repeat (n) begin
            @(posedge sys_clk_in);
            frame <= 1'b1;
            repeat (4) @(posedge sys_clk_in);
            frame <= 1'b0;
            repeat (400) @(posedge sys_clk_in);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // main sequence
    initial begin
        {frame, ee_en, req} = '0;
        rst_in = 1'b1;
        {n_mismatch, cmp_count, cyc, nval} = '0;
        for (int k = 0; k < 256; k++) i_model.mem[k] = 8'hff;
        // image holds no single-shot enable, so no power-down ordering applies
        {i_model.mem[0], i_model.mem[1], i_model.mem[2], i_model.mem[3]} = 32'h00563412;
        {i_model.mem[4], i_model.mem[5], i_model.mem[6], i_model.mem[7]} = 32'h05214365;
        {i_model.mem[8], i_model.mem[9], i_model.mem[10], i_model.mem[11]} = 32'h02480000;
        {i_model.mem[252], i_model.mem[253], i_model.mem[254], i_model.mem[255]} = 32'h09efcdab;
        rst(1'b0);
        wait_done(600);
        $display("absent eeprom test done");
        rst(1'b1);
        acc(1'b1, 8'h05, 24'h111111);
        acc(1'b0, 8'h05, 24'h0);
        chk(r, 24'h0);
        chk({23'h0, done}, 24'h0);
        acc(1'b1, 8'h00, 24'h400000);
        acc(1'b1, 8'h05, 24'h222222);
        acc(1'b0, 8'h05, 24'h0);
        chk(r, 24'h222222);
        $display("override test done");
        rst(1'b1);
        wait_done(25000);
        acc(1'b0, 8'h05, 24'h0);
        chk(r, 24'h654321);
        acc(1'b0, 8'h09, 24'h0);
        chk(r, 24'habcdef);
        acc(1'b0, 8'h00, 24'h0);
        chk(r, 24'h0);
        $display("autoload test done");
        acc(1'b1, 8'h06, 24'h000005);
        acc(1'b1, 8'h07, 24'h0);
        acc(1'b1, 8'h01, 24'h1a0000);
        frames(4);
        chk({12'h0, tval}, 24'h041);
        chk(24'(nval), 24'h1);
        acc(1'b1, 8'h06, 24'h000001);
        acc(1'b1, 8'h07, 24'h810000);
        acc(1'b1, 8'h0d, 24'h800000);
        frames(1);
        chk({12'h0, tval}, 24'h444);
        acc(1'b0, 8'h03, 24'h0);
        chk(r, 24'h000145);
        $display("temperature test done");
        acc(1'b1, 8'h02, 24'h000050);
        acc(1'b1, 8'h07, 24'h01005a);
        acc(1'b1, 8'h03, 24'h004000);
        acc(1'b1, 8'h01, 24'h0c0000);
        acc(1'b1, 8'h01, 24'h080000);
        for (int i = 0; i < 1500 && i_model.mem[32] !== 8'h5a; i++) @(posedge sys_clk_in);
        chk({16'h0, i_model.mem[32]}, 24'h5a);
        $display("eeprom write test done");
        acc(1'b1, 8'h07, 24'h05005a);
        acc(1'b1, 8'h01, 24'h1c0000);
        acc(1'b1, 8'h01, 24'h180000);
        repeat (400) @(posedge sys_clk_in);
        acc(1'b0, 8'h03, 24'h0);
        chk(r, 24'h00415a);
        $display("eeprom read test done");
        end_sim();
    end
endmodule
`default_nettype wire
